//--- rtl/cbsm_top.sv
/*
  cbsm_top: cell balance status monitor with APB register access.
  Assumes a 100 MHz pclk; cell comparison results and exit alerts
  arrive as asynchronous levels and are synchronised here.
*/
// Implementation choice: the APB interface to the registers.
// Operation
// RULE_01: status holds until disable or new launch
// RULE_02: timer status top bits show activity
// RULE_03: undervoltage status mirrors the same activity
// RULE_04: unit field follows selected mode
// RULE_05: 1 Hz counter wraps 0..3 when enabled
// RULE_06: counter keeps running during hold extension
// RULE_07: counter keeps running with infinite expiry
// RULE_08: timer field returns current elapsed count
// RULE_09: hold extension reads back the expiry setting
// RULE_10: infinite expiry timer wraps, never completes
// RULE_11: below-threshold cell sets flag, balancing ends
// RULE_12: cell flags clear only on disable/launch
// RULE_13: unsupported measurement ends cell with flag
// RULE_14: software prepares switch, measurement, unipolar
// RULE_15: status registers read-only, writes ignored
// RULE_16: mode code selects unit and style
// RULE_17: non-zero mode write restarts timer, launches
// RULE_18: launch also clears the activity counter
`timescale 1ns/1ps
`default_nettype none
module cbsm_top #(
  parameter int unsigned TICK_CYCLES = cbsm_pkg::TICK_CYCLES,
  parameter int NCELL = cbsm_pkg::NUM_CELLS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCELL-1:0] cell_below_uv,
  input wire logic [NCELL-1:0] cell_meas_unsupported,
  input wire logic thermal_exit_alert,
  input wire logic timeout_exit_alert,
  input wire logic calibration_fault_alert,
  output logic [NCELL-1:0] cell_balance_on,
  output logic irq
);

  // ==========================================================
  // declarations
  localparam int SW = 2 * NCELL + 3;  // synchronised input bundle
  logic [SW-1:0] pins_sync;           // synchronised pins
  logic [NCELL-1:0] uv_s;             // cell below threshold
  logic [NCELL-1:0] unsup_s;          // cell cannot be checked
  logic halt_s;                       // any exit alert
  logic tick;                         // 1 Hz pulse
  logic [2:0] balance_mode_select;    // control: mode
  logic [1:0] shutdown_hold_mode;     // control: hold mode
  logic uv_check_en;                  // control: threshold checking on
  logic [9:0] balance_expiry_setting; // control: expiry
  cbsm_pkg::cbsm_state_e state;       // engine activity
  logic [9:0] balance_elapsed_timer;  // elapsed count in units
  logic [11:0] sub_count;             // seconds inside one unit
  logic [1:0] activity_tick_counter;  // free 1 Hz counter
  logic [NCELL-1:0] cell_uv_exit_flags; // sticky per-cell exits
  logic [cbsm_pkg::IRQ_W-1:0] irq_status; // sticky events
  logic [cbsm_pkg::IRQ_W-1:0] irq_mask;   // event enables
  logic [cbsm_pkg::IRQ_W-1:0] irq_event;  // this-cycle events
  logic [7:0] idx;                    // register index
  logic wr_acc;                       // write taken this edge
  logic ctl_wr;                       // write to control
  logic balance_launch;               // control write, non-zero mode
  logic balance_stop;                 // control write, mode off
  logic [1:0] timer_unit_indicator;   // unit decoded from mode
  logic [1:0] state_code;             // two-bit activity code
  logic [11:0] unit_len;              // seconds per unit
  logic [NCELL-1:0] next_flags;       // flags with this cycle's exits
  logic [9:0] timer_view;             // timer field as read
  logic [15:0] timer_word;            // timer status word
  logic [15:0] uv_word;               // undervoltage status word
  logic hit;                          // index is mapped
  logic [31:0] rd_mux;                // read data before the flop

  // ==========================================================
  // pin synchronisers and 1 Hz tick
  cbsm_sync #(.WIDTH(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({cell_below_uv, cell_meas_unsupported,
      thermal_exit_alert, timeout_exit_alert, calibration_fault_alert}),
    .sync_out(pins_sync)
  );

  assign uv_s = pins_sync[SW-1 -: NCELL];
  assign unsup_s = pins_sync[NCELL+2 -: NCELL];
  assign halt_s = |pins_sync[2:0];

  // restarting the prescaler keeps the first second of a launch whole
  cbsm_tick #(.PERIOD(TICK_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .restart(balance_launch),
    .tick(tick)
  );

  // ==========================================================
  // apb decode; zero wait states, error on unmapped index
  assign idx = paddr[9:2];
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign ctl_wr = wr_acc && (idx == cbsm_pkg::IDX_CONTROL);
  assign balance_launch = ctl_wr && (pwdata[2:0] != cbsm_pkg::MODE_OFF); // RULE_17
  assign balance_stop = ctl_wr && (pwdata[2:0] == cbsm_pkg::MODE_OFF);
  assign hit = (idx == cbsm_pkg::IDX_TIMER_STATUS) || (idx == cbsm_pkg::IDX_UV_STATUS)
    || (idx == cbsm_pkg::IDX_CONTROL) || (idx == cbsm_pkg::IDX_IRQ_STATUS)
    || (idx == cbsm_pkg::IDX_IRQ_MASK);
  assign pslverr = psel && penable && (!hit || paddr[1:0] != 2'b00);

  // ==========================================================
  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      balance_mode_select <= cbsm_pkg::MODE_OFF;
      shutdown_hold_mode <= cbsm_pkg::HOLD_RESET;
      uv_check_en <= 1'b0;
      balance_expiry_setting <= cbsm_pkg::EXP_RESET;
    end
    else if (ctl_wr)
    begin
      balance_mode_select <= pwdata[cbsm_pkg::CTL_MODE_LSB +: 3];
      shutdown_hold_mode <= pwdata[cbsm_pkg::CTL_HOLD_LSB +: 2];
      uv_check_en <= pwdata[cbsm_pkg::CTL_UVEN_BIT];
      balance_expiry_setting <= pwdata[cbsm_pkg::CTL_EXP_LSB +: 10];
    end
  end

  // ==========================================================
  // mode decode: unit and seconds per timer step
  always_comb
  begin
    if (balance_mode_select == cbsm_pkg::MODE_OFF)
    begin
      timer_unit_indicator = cbsm_pkg::UNIT_NONE;   // RULE_04
      unit_len = 12'h001;
    end
    else if (balance_mode_select == cbsm_pkg::MODE_EMERG_HOURS)
    begin
      timer_unit_indicator = cbsm_pkg::UNIT_HOUR;   // RULE_16
      unit_len = cbsm_pkg::SEC_PER_HOUR;
    end
    else if (balance_mode_select[0])
    begin
      timer_unit_indicator = cbsm_pkg::UNIT_MIN;    // RULE_16
      unit_len = cbsm_pkg::SEC_PER_MIN;
    end
    else
    begin
      timer_unit_indicator = cbsm_pkg::UNIT_SEC;    // RULE_16
      unit_len = 12'h001;
    end
  end

  // ==========================================================
  // per-cell exit flags; a cell that cannot be checked exits too
  assign next_flags = cell_uv_exit_flags
    | ({NCELL{uv_check_en}} & (uv_s | unsup_s)); // RULE_11 RULE_13

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cell_uv_exit_flags <= '0;
    else if (balance_launch || balance_stop)
      cell_uv_exit_flags <= '0;                   // RULE_12
    else if (state == cbsm_pkg::CBSM_RUN)
      cell_uv_exit_flags <= next_flags;           // RULE_11
  end

  // balancing of a flagged cell ends at once
  assign cell_balance_on = (state == cbsm_pkg::CBSM_RUN) ? ~cell_uv_exit_flags : '0; // RULE_11

  // ==========================================================
  // activity state; halt outranks normal completion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= cbsm_pkg::CBSM_OFF;
    else if (balance_stop)
      state <= cbsm_pkg::CBSM_OFF;
    else if (balance_launch)
      state <= cbsm_pkg::CBSM_RUN;                // RULE_17
    else if (state == cbsm_pkg::CBSM_RUN)
    begin
      if (halt_s)
        state <= cbsm_pkg::CBSM_HALT;             // RULE_02
      else if (&cell_uv_exit_flags)
        state <= cbsm_pkg::CBSM_DONE;
      // infinite expiry never completes on time
      else if (balance_expiry_setting != cbsm_pkg::EXP_INFINITE
        && balance_elapsed_timer == balance_expiry_setting)
        state <= cbsm_pkg::CBSM_DONE;             // RULE_10
    end
  end

  always_comb
  begin
    unique case (state)
      cbsm_pkg::CBSM_OFF: state_code = cbsm_pkg::IND_OFF;
      cbsm_pkg::CBSM_RUN: state_code = cbsm_pkg::IND_ACTIVE;
      cbsm_pkg::CBSM_DONE: state_code = cbsm_pkg::IND_DONE;
      cbsm_pkg::CBSM_HALT: state_code = cbsm_pkg::IND_HALT;
    endcase
  end

  // ==========================================================
  // elapsed timer; frozen once the operation has ended
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      balance_elapsed_timer <= '0;
      sub_count <= '0;
    end
    else if (balance_launch || balance_stop)
    begin
      balance_elapsed_timer <= '0;                // RULE_17 RULE_01
      sub_count <= '0;
    end
    else if (tick && state == cbsm_pkg::CBSM_RUN)
    begin
      if (sub_count + 12'h001 >= unit_len)
      begin
        sub_count <= '0;
        balance_elapsed_timer <= balance_elapsed_timer + 10'h001; // RULE_08 RULE_10
      end
      else
        sub_count <= sub_count + 12'h001;
    end
  end

  // ==========================================================
  // 1 Hz activity counter: runs whenever a mode is selected
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      activity_tick_counter <= '0;
    else if (balance_launch || balance_stop)
      activity_tick_counter <= '0;                // RULE_18
    else if (tick && balance_mode_select != cbsm_pkg::MODE_OFF)
      activity_tick_counter <= activity_tick_counter + 2'h1; // RULE_05 RULE_06 RULE_07
  end

  // ==========================================================
  // status words; hold extension shows the expiry as a done marker
  assign timer_view = (state == cbsm_pkg::CBSM_DONE && shutdown_hold_mode[1])
    ? balance_expiry_setting : balance_elapsed_timer; // RULE_09
  assign timer_word = {state_code, timer_unit_indicator, activity_tick_counter,
    timer_view};                                  // RULE_02 RULE_04 RULE_08
  assign uv_word = {state_code, cell_uv_exit_flags}; // RULE_03

  // ==========================================================
  // interrupt events, sticky, write one to clear, set wins
  assign irq_event[0] = (state == cbsm_pkg::CBSM_RUN) && !halt_s && !balance_stop
    && !balance_launch && (&cell_uv_exit_flags || (balance_expiry_setting
    != cbsm_pkg::EXP_INFINITE && balance_elapsed_timer == balance_expiry_setting));
  assign irq_event[1] = (state == cbsm_pkg::CBSM_RUN) && halt_s && !ctl_wr;
  assign irq_event[2] = (state == cbsm_pkg::CBSM_RUN) && !ctl_wr
    && (next_flags != cell_uv_exit_flags);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= '0;
      irq_mask <= '0;
    end
    else
    begin
      if (wr_acc && idx == cbsm_pkg::IDX_IRQ_STATUS)
        irq_status <= (irq_status & ~pwdata[cbsm_pkg::IRQ_W-1:0]) | irq_event;
      else
        irq_status <= irq_status | irq_event;
      if (wr_acc && idx == cbsm_pkg::IDX_IRQ_MASK)
        irq_mask <= pwdata[cbsm_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ==========================================================
  // read path; the status words have no write path at all
  always_comb
  begin
    rd_mux = '0;
    if (idx == cbsm_pkg::IDX_TIMER_STATUS)
      rd_mux = {16'h0000, timer_word};            // RULE_15
    else if (idx == cbsm_pkg::IDX_UV_STATUS)
      rd_mux = {16'h0000, uv_word};               // RULE_15
    else if (idx == cbsm_pkg::IDX_CONTROL)
      rd_mux = {6'h00, balance_expiry_setting, 10'h000, uv_check_en,
        shutdown_hold_mode, balance_mode_select};
    else if (idx == cbsm_pkg::IDX_IRQ_STATUS)
      rd_mux = {29'h0, irq_status};
    else if (idx == cbsm_pkg::IDX_IRQ_MASK)
      rd_mux = {29'h0, irq_mask};
  end

  // sampled in the setup phase so prdata is a flop in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_launch;
    ctl_wr && balance_launch;
  endsequence

  a_mirror_same: assert property (timer_word[15:14] == uv_word[15:14]) // RULE_03
    else $error("activity mirrors differ");
  a_launch_clears: assert property (s_launch |=> state == cbsm_pkg::CBSM_RUN
    && balance_elapsed_timer == 10'h000 && activity_tick_counter == 2'h0
    && cell_uv_exit_flags == '0) // RULE_17
    else $error("launch did not restart");
  a_stop_clears: assert property (balance_stop |=> timer_word == cbsm_pkg::STATUS_RESET
    && uv_word == cbsm_pkg::STATUS_RESET) // RULE_01
    else $error("disable did not clear status");
  a_flags_sticky: assert property (!ctl_wr |=> (cell_uv_exit_flags
    & $past(cell_uv_exit_flags)) == $past(cell_uv_exit_flags)) // RULE_12
    else $error("cell flag cleared without control write");
  a_uv_sets: assert property (state == cbsm_pkg::CBSM_RUN && uv_check_en && !ctl_wr
    |=> cell_uv_exit_flags == $past(next_flags)) // RULE_11
    else $error("cell flag not set");
  a_unit_hour: assert property (balance_mode_select == cbsm_pkg::MODE_EMERG_HOURS
    |-> timer_word[13:12] == cbsm_pkg::UNIT_HOUR) // RULE_04
    else $error("hour unit not reported");
  a_cntr_step: assert property (tick && balance_mode_select != cbsm_pkg::MODE_OFF && !ctl_wr
    |=> activity_tick_counter == $past(activity_tick_counter) + 2'h1) // RULE_05
    else $error("activity counter did not step");
  a_hold_view: assert property (state == cbsm_pkg::CBSM_DONE && shutdown_hold_mode[1]
    |-> timer_word[9:0] == balance_expiry_setting) // RULE_09
    else $error("hold readback wrong");
  a_inf_runs: assert property (state == cbsm_pkg::CBSM_RUN && !halt_s && !ctl_wr
    && balance_expiry_setting == cbsm_pkg::EXP_INFINITE && !(&cell_uv_exit_flags)
    |=> state == cbsm_pkg::CBSM_RUN) // RULE_10
    else $error("infinite expiry ended balancing");
  a_ro_status: assert property (wr_acc && (idx == cbsm_pkg::IDX_TIMER_STATUS
    || idx == cbsm_pkg::IDX_UV_STATUS) |=> $stable(balance_mode_select)
    && $stable(irq_mask)) // RULE_15
    else $error("status write had an effect");

endmodule : cbsm_top
`default_nettype wire

//--- rtl/cbsm_pkg.sv
/*
  cbsm_pkg: constants for the cell balance status monitor.
  Assumes a 100 MHz pclk and a 32-bit APB slave with word-aligned registers.
*/
package cbsm_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_CELLS = 14;
  localparam int TIMER_W = 10;

  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_TIMER_STATUS = 8'h81;
  localparam logic [7:0] IDX_UV_STATUS = 8'h82;
  localparam logic [7:0] IDX_CONTROL = 8'h90;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h91;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h92;

  // ==========================================================
  // field positions
  localparam int STATE_LSB = 14;   // two-bit activity indicator, both status words
  localparam int UNIT_LSB = 12;    // timer unit
  localparam int CNTR_LSB = 10;    // 1 Hz activity counter
  localparam int CTL_MODE_LSB = 0;   // control: mode select [2:0]
  localparam int CTL_HOLD_LSB = 3;   // control: shutdown hold mode [4:3]
  localparam int CTL_UVEN_BIT = 5;   // control: undervoltage checking enable
  localparam int CTL_EXP_LSB = 16;   // control: expiry setting [25:16]
  localparam int IRQ_W = 3;          // done, halt, new undervoltage flag

  // ==========================================================
  // reset values and codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EMERG_HOURS = 3'h1;
  localparam logic [9:0] EXP_INFINITE = 10'h3ff;
  localparam logic [9:0] EXP_RESET = 10'h000;
  localparam logic [1:0] HOLD_RESET = 2'h0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  localparam logic [1:0] IND_OFF = 2'h0;
  localparam logic [1:0] IND_ACTIVE = 2'h1;
  localparam logic [1:0] IND_DONE = 2'h2;
  localparam logic [1:0] IND_HALT = 2'h3;
  localparam logic [1:0] UNIT_NONE = 2'h0;
  localparam logic [1:0] UNIT_SEC = 2'h1;
  localparam logic [1:0] UNIT_MIN = 2'h2;
  localparam logic [1:0] UNIT_HOUR = 2'h3;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] SEC_PER_MIN = 12'h03c;
  localparam logic [11:0] SEC_PER_HOUR = 12'he10;

  // activity of the balancing engine
  typedef enum logic [1:0] {CBSM_OFF, CBSM_RUN, CBSM_DONE, CBSM_HALT} cbsm_state_e;

endpackage : cbsm_pkg

//--- rtl/cbsm_sync.sv
/*
  cbsm_sync: two-flop synchroniser for a bus of independent levels.
  Assumes each bit is a slow level; no bit-to-bit coherence is kept.
*/
`timescale 1ns/1ps
`default_nettype none
module cbsm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================
  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : cbsm_sync
`default_nettype wire

//--- rtl/cbsm_tick.sv
/*
  cbsm_tick: divides pclk down to a one-cycle 1 Hz tick.
  Assumes restart is a same-clock pulse; it realigns the second boundary.
*/
`timescale 1ns/1ps
`default_nettype none
module cbsm_tick #(
  parameter int unsigned PERIOD = cbsm_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  output logic tick
);

  localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  // ==========================================================
  // prescaler; restart makes the next second a full one
  logic [CW-1:0] count;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (restart)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (count == LAST);
      count <= (count == LAST) ? '0 : count + 1'b1;
    end
  end

endmodule : cbsm_tick
`default_nettype wire

//--- verif/cbsm_top_tb.sv
/*
  cbsm_top_tb: self-checking bench for the cell balance status monitor.
  Assumes cbsm_pkg is compiled first; TICK_CYCLES is cut to 10 for speed.
*/
`timescale 1ns/1ps
`default_nettype none
module cbsm_top_tb;
  // ==========================================================
  // signals
  localparam int TK = 10; // shortened 1 Hz divider
  logic pclk, presetn, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, irq, err;
  logic [13:0] below, unsup, bal_on;
  logic [2:0] alrt; // thermal, timeout, calibration
  int fails, num_checks, cyc, t0;
  logic [1:0] unit_of [8] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2};

  cbsm_top #(.TICK_CYCLES(TK), .NCELL(14)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_below_uv(below),
    .cell_meas_unsupported(unsup), .thermal_exit_alert(alrt[0]),
    .timeout_exit_alert(alrt[1]), .calibration_fault_alert(alrt[2]),
    .cell_balance_on(bal_on), .irq(irq));

  // ==========================================================
  // clock, cycle count and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ceiling well above the ~11k cycles the run needs
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      end_sim();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer plus an idle cycle, so back-to-back calls never clash
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit of its own here; a hang is ended by the cycle ceiling
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    if (wr)
      t0 = cyc; // launch edge reference for timed reads
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // read whose setup edge lands 'at' edges after the last write
  task automatic rd_at(input int at, input logic [7:0] idx);
    while (cyc - t0 < at - 1)
      @(posedge pclk);
    apb(1'b0, idx, 32'h0);
  endtask : rd_at

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] h,
                                      input logic uv, input logic [9:0] e);
    return {6'h0, e, 10'h0, uv, h, m};
  endfunction : ctl

  // ==========================================================
  // scenarios
  // reset values, read-only status, unmapped index
  task automatic t_reset;
    apb(1'b1, 8'h81, 32'hffff);
    apb(1'b1, 8'h82, 32'hffff);
    chk(err, 0);
    chk(pready, 1);
    apb(1'b0, 8'h81, 0);
    chk(rd, 0);
    apb(1'b0, 8'h82, 0);
    chk(rd, 0);
    apb(1'b0, 8'h10, 0);
    chk({rd[30:0], err}, 1);
  endtask : t_reset

  // every mode code: state, unit and mirror just after launch
  task automatic t_modes;
    for (int m = 0; m < 8; m++)
    begin
      apb(1'b1, 8'h90, ctl(m[2:0], 2'h0, 1'b0, 10'h3ff));
      rd_at(2, 8'h81);
      chk(rd, {16'h0, (m == 0) ? 2'h0 : 2'h1, unit_of[m], 12'h0});
      apb(1'b0, 8'h82, 0);
      chk(rd, {16'h0, (m == 0) ? 2'h0 : 2'h1, 14'h0});
    end
  endtask : t_modes

  // seconds mode to expiry 5, then status persists after done
  task automatic t_expiry;
    apb(1'b1, 8'h90, ctl(3'h2, 2'h0, 1'b0, 10'h5));
    rd_at(36, 8'h81);
    chk(rd, {16'h0, 2'h1, 2'h1, 2'h3, 10'h3});
    rd_at(76, 8'h81);
    chk(rd, {16'h0, 2'h2, 2'h1, 2'h3, 10'h5});
    apb(1'b0, 8'h82, 0);
    chk(rd, {16'h0, 2'h2, 14'h0});
  endtask : t_expiry

  // all cells below threshold with hold extension, then irq path
  task automatic t_hold;
    apb(1'b1, 8'h91, 32'h7);
    apb(1'b1, 8'h90, ctl(3'h2, 2'h2, 1'b1, 10'h20));
    rd_at(15, 8'h81);
    below <= 14'h3fff;
    rd_at(66, 8'h81);
    chk(rd, {16'h0, 2'h2, 2'h1, 2'h2, 10'h20});
    apb(1'b0, 8'h82, 0);
    chk(rd, {16'h0, 2'h2, 14'h3fff});
    chk(bal_on, 0);
    below <= 14'h0;
    apb(1'b0, 8'h91, 0);
    chk(rd, 32'h5);
    chk(irq, 0);
    apb(1'b1, 8'h92, 32'h5);
    chk(irq, 1);
    apb(1'b1, 8'h91, 32'h5);
    chk(irq, 0);
  endtask : t_hold

  // each exit alert halts a running operation
  task automatic t_halt;
    apb(1'b1, 8'h92, 32'h2);
    for (int a = 0; a < 3; a++)
    begin
      apb(1'b1, 8'h90, ctl(3'h2, 2'h0, 1'b0, 10'h3ff));
      rd_at(15, 8'h82);
      alrt <= 3'h1 << a;
      rd_at(26, 8'h81);
      chk(rd, {16'h0, 2'h3, 2'h1, 2'h2, 10'h1});
      chk(irq, 1);
      alrt <= 3'h0;
      apb(1'b1, 8'h91, 32'h2);
      chk(irq, 0);
    end
  endtask : t_halt

  // unsupported cell measurement, relaunch, then disable
  task automatic t_unsup;
    apb(1'b1, 8'h90, ctl(3'h4, 2'h0, 1'b1, 10'h3ff));
    unsup <= 14'h0008;
    rd_at(36, 8'h81);
    chk(rd, {16'h0, 2'h1, 2'h1, 2'h3, 10'h3});
    apb(1'b0, 8'h82, 0);
    chk(rd, {16'h0, 2'h1, 14'h0008});
    chk(bal_on, 14'h3ff7);
    unsup <= 14'h0;
    apb(1'b0, 8'h91, 0);
    chk(rd, 32'h4);
    apb(1'b1, 8'h90, ctl(3'h4, 2'h0, 1'b1, 10'h3ff));
    rd_at(2, 8'h81);
    chk(rd, {16'h0, 2'h1, 2'h1, 12'h0});
    apb(1'b0, 8'h82, 0);
    chk(rd, {16'h0, 2'h1, 14'h0});
    apb(1'b1, 8'h90, 32'h0);
    apb(1'b0, 8'h81, 0);
    chk(rd, 0);
    chk(bal_on, 0);
  endtask : t_unsup

  // infinite expiry: timer wraps past 1023 and keeps running
  task automatic t_infinite;
    apb(1'b1, 8'h90, ctl(3'h2, 2'h0, 1'b0, 10'h3ff));
    rd_at(10256, 8'h81);
    chk(rd, {16'h0, 2'h1, 2'h1, 2'h1, 10'h1});
  endtask : t_infinite

  // ==========================================================
  // closing report, the only exit
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // ==========================================================
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata} = 64'h0;
    {below, unsup, alrt} = 31'h0;
    {fails, num_checks, cyc, t0} = 128'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({bal_on, irq}, 0);
    t_reset();
    t_modes();
    t_expiry();
    t_hold();
    t_halt();
    t_unsup();
    t_infinite();
    end_sim();
  end
endmodule : cbsm_top_tb
`default_nettype wire
